// ==== design/fhp_pkg.sv ====
package fhp_pkg;
  localparam int          DW             = 8;
  localparam int          FIFO_DEPTH     = 16;
  // status register bit positions
  localparam int          ST_TXR         = 7;
  localparam int          ST_DIR         = 6;
  localparam int          ST_PIO         = 5;
  localparam int          ST_BSY         = 4;
  localparam logic [7:0]  ABORT_CODE     = 8'hFF;
  localparam logic [7:0]  LCT_DEFAULT    = 8'h2B;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic        REG_STATUS     = 1'b0;
  localparam logic        REG_DATA       = 1'b1;
  localparam logic        STYLE_SEP_STRB = 1'b0;
  localparam logic        STYLE_EN_DIR   = 1'b1;
  localparam logic        DIR_OUTWARD    = 1'b0;
  localparam logic        DIR_INWARD     = 1'b1;
  // bit-cell rates in kbit/s
  localparam int          RATE_FM_SMALL  = 125;
  localparam int          RATE_MFM_SMALL = 250;
  localparam int          RATE_FM_SMALL_ALT  = 150;
  localparam int          RATE_MFM_SMALL_ALT = 300;
  localparam int          RATE_FM_LARGE  = 250;
  localparam int          RATE_MFM_LARGE = 500;
  localparam int          CLK_MHZ        = 200;
  // step pulse width in ns
  localparam int          STEP_NS        = 1000;
  localparam int          STEP_CYC       = (STEP_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    FHP_IDLE = 2'b00,
    FHP_BUSY = 2'b01,
    FHP_XFER = 2'b11,
    FHP_SEEK = 2'b10
  } fhp_state_t;
endpackage : fhp_pkg

// ==== design/fhp_fifo.sv ====
`timescale 1ns/10ps
module fhp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  input  wire logic             flush_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fhp_fifo_st_t;
  fhp_fifo_st_t st_r;
  fhp_fifo_st_t st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign empty       = st_r.wp == st_r.rp;
  assign full        = (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]) && (st_r.wp[AW] != st_r.rp[AW]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[st_r.rp[AW-1:0]];
  assign push        = in_valid_i && !full && !flush_i;
  assign pop         = out_ready_i && !empty && !flush_i;

  always_comb begin
    st_nxt = st_r;
    if (flush_i) begin
      st_nxt.wp = '0;
      st_nxt.rp = '0;
    end
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[st_r.wp[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : fhp_fifo

// ==== design/fhp_port.sv ====
`timescale 1ns/10ps
module fhp_port (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       host_bus_style_strap_i,
  input  wire logic       format_style_strap_i,
  input  wire logic       drive_size_strap_i,
  input  wire logic       chip_sel_n_i,
  input  wire logic       register_pick_i,
  input  wire logic       strobe_a_i,
  input  wire logic       strobe_b_i,
  input  wire logic [7:0] data_in_i,
  output logic      [7:0] data_out_o,
  output logic            data_oe_o,
  output logic            irq_n_o,
  output logic            irq_oe_o,
  output logic            dma_ask_n_o,
  input  wire logic       dma_grant_n_i,
  input  wire logic       dma_terminate_n_i,
  input  wire logic       cmd_start_i,
  input  wire logic       cmd_is_seek_i,
  input  wire logic       cmd_host_reads_i,
  input  wire logic       cmd_use_dma_i,
  input  wire logic       cmd_rw_i,
  input  wire logic [1:0] cmd_drive_i,
  input  wire logic       cmd_head_i,
  input  wire logic [7:0] cmd_track_i,
  input  wire logic       cmd_inward_i,
  input  wire logic       cmd_setup2_i,
  input  wire logic [7:0] cmd_lct_track_i,
  input  wire logic       cmd_done_i,
  input  wire logic       cmd_step_i,
  input  wire logic       cmd_fault_clear_i,
  input  wire logic       cmd_head_engage_i,
  input  wire logic [7:0] ctl_rd_data_i,
  input  wire logic       ctl_rd_valid_i,
  output logic            ctl_rd_ready_o,
  output logic      [7:0] ctl_wr_data_o,
  output logic            ctl_wr_valid_o,
  input  wire logic       ctl_wr_ready_i,
  output logic            abort_o,
  output logic            drive_pick_0_o,
  output logic            drive_pick_1_o,
  output logic            head_step_way_o,
  output logic            head_side_o,
  output logic            reduced_write_current_o,
  output logic            drive_fault_clear_o,
  output logic            head_engage_o,
  output logic            step_o,
  output logic            format_layout_o,
  output logic [9:0]      bit_rate_kbps_o
);
  typedef struct packed {
    logic [2:0]           cs_s;
    logic [2:0]           a_s;
    logic [2:0]           b_s;
    logic [2:0]           gr_s;
    logic [2:0]           te_s;
    logic                 acc;
    logic                 acc_rd;
    logic                 acc_data;
    fhp_pkg::fhp_state_t  state;
    logic                 host_reads;
    logic                 use_dma;
    logic                 rw_cmd;
    logic [3:0]           seek;
    logic [1:0]           drive;
    logic                 head;
    logic                 way;
    logic [7:0]           lct_trk;
    logic                 reduced_write_current;
    logic                 irq;
    logic [7:0]           dout;
    logic [7:0]           wdata;
    logic                 wpend;
    logic                 abort;
    logic                 fault_clr;
    logic                 engage;
    logic                 step;
    logic                 sstyle;
    logic                 fstyle;
    logic                 dsize;
  } fhp_st_t;

  fhp_st_t    st_r;
  fhp_st_t    st_nxt;
  logic [7:0] fifo_out;
  logic       fifo_out_valid;
  logic       fifo_in_ready;
  logic       fifo_pop;
  logic       fifo_flush;
  logic       transfer_ready_flag;
  logic [7:0] status;

  function automatic logic agreed(input logic [2:0] s);
    agreed = s[1] & s[2];
  endfunction : agreed

  function automatic logic settled(input logic [2:0] s, input logic cur);
    settled = (s[1] == s[2]) ? s[2] : cur;
  endfunction : settled

  logic cs_act;
  logic a_lvl;
  logic b_lvl;
  logic grant;
  logic term;
  logic rd_req;
  logic wr_req;
  logic any_req;

  assign cs_act = !settled(st_r.cs_s, 1'b1);
  assign a_lvl  = settled(st_r.a_s, 1'b1);
  assign b_lvl  = settled(st_r.b_s, 1'b1);
  assign grant  = !settled(st_r.gr_s, 1'b1);
  assign term   = !settled(st_r.te_s, 1'b1);

  always_comb begin
    if (st_r.sstyle == fhp_pkg::STYLE_SEP_STRB) begin
      rd_req = !a_lvl;
      wr_req = !b_lvl;
    end else begin
      rd_req = a_lvl && b_lvl;
      wr_req = a_lvl && !b_lvl;
    end
  end

  assign any_req = (cs_act || grant) && (rd_req || wr_req);

  assign transfer_ready_flag = (st_r.state == fhp_pkg::FHP_XFER) && !st_r.acc && !st_r.wpend &&
               (st_r.host_reads ? fifo_out_valid : fifo_in_ready);

  always_comb begin
    status = fhp_pkg::STATUS_RESET;
    status[fhp_pkg::ST_TXR] = transfer_ready_flag;
    status[fhp_pkg::ST_DIR] = st_r.host_reads;
    status[fhp_pkg::ST_PIO] = st_r.rw_cmd && !st_r.use_dma &&
                              (st_r.state == fhp_pkg::FHP_XFER);
    status[fhp_pkg::ST_BSY] = st_r.state != fhp_pkg::FHP_IDLE;
    status[3:0] = st_r.seek;
  end

  logic access_start;
  logic is_data;
  assign access_start = any_req && !st_r.acc;
  assign is_data = grant || (register_pick_i == fhp_pkg::REG_DATA);
  assign fifo_pop = access_start && rd_req && is_data && st_r.host_reads && fifo_out_valid;
  assign fifo_flush = st_r.abort || (st_r.state == fhp_pkg::FHP_IDLE);

  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_s = {st_r.cs_s[1:0], chip_sel_n_i};
    st_nxt.a_s  = {st_r.a_s[1:0], strobe_a_i};
    st_nxt.b_s  = {st_r.b_s[1:0], strobe_b_i};
    st_nxt.gr_s = {st_r.gr_s[1:0], dma_grant_n_i};
    st_nxt.te_s = {st_r.te_s[1:0], dma_terminate_n_i};
    st_nxt.abort = 1'b0;
    st_nxt.acc = any_req;
    // straps are static, so a plain register is enough for them
    st_nxt.sstyle = host_bus_style_strap_i;
    st_nxt.fstyle = format_style_strap_i;
    st_nxt.dsize  = drive_size_strap_i;
    if (access_start) begin
      st_nxt.acc_rd   = rd_req;
      st_nxt.acc_data = is_data;
      if (rd_req) begin
        st_nxt.dout = is_data ? fifo_out : status;
      end else if (is_data) begin
        st_nxt.wdata = data_in_i;
        st_nxt.wpend = 1'b1;
      end else if (data_in_i == fhp_pkg::ABORT_CODE) begin
        st_nxt.abort = 1'b1;
      end
      if (is_data) begin
        st_nxt.irq = 1'b0;
      end
    end
    if (st_r.wpend && ctl_wr_ready_i) begin
      st_nxt.wpend = 1'b0;
    end
    unique case (st_r.state)
      fhp_pkg::FHP_IDLE: begin
        if (cmd_start_i) begin
          st_nxt.host_reads = cmd_host_reads_i;
          st_nxt.use_dma    = cmd_use_dma_i;
          st_nxt.rw_cmd     = cmd_rw_i;
          st_nxt.drive      = cmd_drive_i;
          st_nxt.head       = cmd_head_i;
          st_nxt.way        = cmd_inward_i;
          st_nxt.state      = cmd_is_seek_i ? fhp_pkg::FHP_SEEK : fhp_pkg::FHP_BUSY;
          if (cmd_is_seek_i) begin
            st_nxt.seek[cmd_drive_i] = 1'b1;
          end
        end
      end
      fhp_pkg::FHP_BUSY: begin
        st_nxt.state = fhp_pkg::FHP_XFER;
      end
      fhp_pkg::FHP_XFER: begin
        if (cmd_done_i || (st_r.use_dma && term)) begin
          st_nxt.state = fhp_pkg::FHP_IDLE;
          st_nxt.irq   = 1'b1;
        end else if (!st_r.use_dma && transfer_ready_flag) begin
          st_nxt.irq = 1'b1;
        end
      end
      fhp_pkg::FHP_SEEK: begin
        if (cmd_done_i) begin
          st_nxt.state = fhp_pkg::FHP_IDLE;
          st_nxt.irq   = 1'b1;
          st_nxt.seek[st_r.drive] = 1'b0;
        end
      end
    endcase
    if (cmd_setup2_i) begin
      st_nxt.lct_trk = cmd_lct_track_i;
    end
    st_nxt.reduced_write_current       = cmd_track_i >= st_r.lct_trk;
    st_nxt.fault_clr = cmd_fault_clear_i;
    st_nxt.engage    = cmd_head_engage_i;
    st_nxt.step      = cmd_step_i;
    if (st_r.abort) begin
      st_nxt.state = fhp_pkg::FHP_IDLE;
      st_nxt.seek  = '0;
      st_nxt.wpend = 1'b0;
      st_nxt.irq   = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r         <= '0;
      st_r.cs_s    <= 3'h7;
      st_r.a_s     <= 3'h7;
      st_r.b_s     <= 3'h7;
      st_r.gr_s    <= 3'h7;
      st_r.te_s    <= 3'h7;
      st_r.state   <= fhp_pkg::FHP_IDLE;
      st_r.lct_trk <= fhp_pkg::LCT_DEFAULT;
      st_r.sstyle  <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // strap_taken_r marks release but is unused; straps are re-registered every cycle
  logic strap_taken_r;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      strap_taken_r <= 1'b0;
    end else begin
      strap_taken_r <= 1'b1;
    end
  end
  logic unused_strap;
  assign unused_strap = strap_taken_r;

  fhp_fifo #(
    .WIDTH (fhp_pkg::DW),
    .DEPTH (fhp_pkg::FIFO_DEPTH)
  ) u_rx (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .in_data_i   (ctl_rd_data_i),
    .in_valid_i  (ctl_rd_valid_i),
    .in_ready_o  (ctl_rd_ready_o),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .flush_i     (fifo_flush)
  );
  assign fifo_in_ready = !st_r.wpend;

  assign data_out_o = st_r.dout;
  assign data_oe_o  = st_r.acc && st_r.acc_rd && any_req && rd_req;
  assign ctl_wr_data_o  = st_r.wdata;
  assign ctl_wr_valid_o = st_r.wpend;
  assign abort_o        = st_r.abort;
  assign irq_n_o = !st_r.irq;
  assign irq_oe_o = (st_r.sstyle == fhp_pkg::STYLE_EN_DIR) ? st_r.irq : 1'b1;
  assign dma_ask_n_o = !(st_r.use_dma && st_r.state == fhp_pkg::FHP_XFER && transfer_ready_flag);
  assign drive_pick_0_o = st_r.drive[0];
  assign drive_pick_1_o = st_r.drive[1];
  assign head_step_way_o = st_r.way ? fhp_pkg::DIR_INWARD : fhp_pkg::DIR_OUTWARD;
  assign head_side_o = st_r.head;
  assign reduced_write_current_o = st_r.reduced_write_current;
  assign drive_fault_clear_o = st_r.fault_clr;
  assign head_engage_o = st_r.engage;
  assign step_o = st_r.step;
  assign format_layout_o = st_r.fstyle;
  always_comb begin
    if (st_r.dsize) begin
      bit_rate_kbps_o = st_r.rw_cmd ? 10'(fhp_pkg::RATE_MFM_LARGE) : 10'(fhp_pkg::RATE_FM_LARGE);
    end else begin
      bit_rate_kbps_o = st_r.rw_cmd ? 10'(fhp_pkg::RATE_MFM_SMALL) : 10'(fhp_pkg::RATE_FM_SMALL);
    end
  end
endmodule : fhp_port

// ==== test/fhp_port_chk.sv ====
`timescale 1ns/10ps
module fhp_port_chk (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       host_bus_style_strap_i,
  input  wire logic       chip_sel_n_i,
  input  wire logic       register_pick_i,
  input  wire logic       strobe_a_i,
  input  wire logic       strobe_b_i,
  input  wire logic [7:0] data_in_i,
  input  wire logic       data_oe_o,
  input  wire logic       irq_n_o,
  input  wire logic       irq_oe_o,
  input  wire logic       dma_ask_n_o,
  input  wire logic       dma_grant_n_i,
  input  wire logic       abort_o,
  input  wire logic       ctl_wr_valid_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // reset levels hold while reset is high, so this one ignores the default disable
  property p_rst;
    disable iff (1'h0) reset_i |-> irq_n_o && dma_ask_n_o && !data_oe_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset levels wrong");
  property p_oe_cs;
    $rose(data_oe_o) |-> $past(!chip_sel_n_i || !dma_grant_n_i, 2);
  endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("bus driven while unselected");
  property p_oe_rd;
    $rose(data_oe_o) |->
      (host_bus_style_strap_i ? $past(strobe_b_i, 2) : !$past(strobe_a_i, 2));
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("bus driven outside a read");
  property p_irq_cmos;
    !host_bus_style_strap_i |=> irq_oe_o;
  endproperty
  a_irq_cmos: assert property (p_irq_cmos) else $error("irq not driven");
  property p_irq_od;
    host_bus_style_strap_i && irq_oe_o |-> !irq_n_o;
  endproperty
  a_irq_od: assert property (p_irq_od) else $error("irq drives high");
  property p_abt_pulse;
    abort_o |=> !abort_o;
  endproperty
  a_abt_pulse: assert property (p_abt_pulse) else $error("abort pulse too long");
  property p_abt_src;
    abort_o |-> $past(data_in_i) == fhp_pkg::ABORT_CODE && $past(!chip_sel_n_i && !register_pick_i);
  endproperty
  a_abt_src: assert property (p_abt_src) else $error("abort without code");
  property p_wr_src;
    $rose(ctl_wr_valid_o) |-> $past(!dma_grant_n_i || (!chip_sel_n_i && register_pick_i), 2);
  endproperty
  a_wr_src: assert property (p_wr_src) else $error("data write from wrong place");
endmodule : fhp_port_chk

bind fhp_port fhp_port_chk i_chk (.*);

// ==== test/fhp_host_mdl.sv ====
`timescale 1ns/10ps
// host cpu and dma controller; only the separate-strobe style is modelled
module fhp_host_mdl (
  input  wire logic       mclk_i,
  input  wire logic [7:0] data_i,
  output logic            chip_sel_n_o,
  output logic            pick_o,
  output logic            strobe_a_o,
  output logic            strobe_b_o,
  output logic      [7:0] data_o,
  output logic            grant_n_o,
  output logic            terminate_n_o
);
  initial begin
    chip_sel_n_o = 1'h1;
    grant_n_o = 1'h1;
    terminate_n_o = 1'h1;
    strobe_a_o = 1'h1;
    strobe_b_o = 1'h1;
    pick_o = 1'h0;
    data_o = 8'h00;
  end
  // strobe held past the sync delay
  task xfer(input logic dma, input logic rd, input logic pk, input logic [7:0] wd,
            output logic [7:0] rdat);
    @(negedge mclk_i);
    pick_o = pk;
    data_o = wd;
    chip_sel_n_o = dma;
    grant_n_o = !dma;
    strobe_a_o = !rd;
    strobe_b_o = rd;
    repeat (6) @(posedge mclk_i);
    rdat = data_i;
    @(negedge mclk_i);
    strobe_a_o = 1'h1;
    strobe_b_o = 1'h1;
    chip_sel_n_o = 1'h1;
    grant_n_o = 1'h1;
    // released lines must not keep the last value
    data_o = ~wd;
    pick_o = ~pk;
    repeat (5) @(negedge mclk_i);
  endtask : xfer
  task end_dma;
    @(negedge mclk_i);
    terminate_n_o = 1'h0;
    // held long enough for the three-stage synchroniser to agree
    repeat (4) @(negedge mclk_i);
    terminate_n_o = 1'h1;
  endtask : end_dma
endmodule : fhp_host_mdl

// ==== test/fhp_port_tb.sv ====
`timescale 1ns/10ps
module fhp_port_tb;
  typedef struct packed {logic [14:0] stim; logic [7:0] want;} fhp_row_t;
  logic       mclk_i = 1'h0, reset_i;
  logic       host_bus_style_strap_i = 1'h0, format_style_strap_i = 1'h0;
  logic       drive_size_strap_i = 1'h0;
  wire logic  chip_sel_n_i, register_pick_i, strobe_a_i, strobe_b_i;
  wire logic  dma_grant_n_i, dma_terminate_n_i;
  wire logic [7:0] data_in_i;
  logic [7:0] data_out_o, ctl_wr_data_o, rd;
  logic [7:0] cmd_track_i = 8'h00, cmd_lct_track_i = 8'h00, ctl_rd_data_i = 8'h00;
  logic       data_oe_o, irq_n_o, irq_oe_o, dma_ask_n_o, ctl_rd_ready_o, ctl_wr_valid_o;
  logic       abort_o, drive_pick_0_o, drive_pick_1_o, head_step_way_o, head_side_o;
  logic       reduced_write_current_o, drive_fault_clear_o, head_engage_o, step_o;
  logic       format_layout_o;
  logic [9:0] bit_rate_kbps_o;
  logic       cmd_start_i = 1'h0, cmd_is_seek_i = 1'h0, cmd_host_reads_i = 1'h0;
  logic       cmd_use_dma_i = 1'h0, cmd_rw_i = 1'h0, cmd_head_i = 1'h0, cmd_inward_i = 1'h0;
  logic       cmd_setup2_i = 1'h0, cmd_done_i = 1'h0, cmd_step_i = 1'h0;
  logic       cmd_fault_clear_i = 1'h0, cmd_head_engage_i = 1'h0, ctl_rd_valid_i = 1'h0;
  logic       ctl_wr_ready_i = 1'h1;
  logic [1:0] cmd_drive_i = 2'h0;
  int         n_fail = 0, compares = 0, cyc = 0, n_abort = 0, n_wr = 0, n;
  // drive, head, way, track, step/clear/engage beside picks, side, way, low current, step/clear/engage
  fhp_row_t   rows [4] = '{{2'h0, 1'h0, 1'h0, 8'h00, 3'h0, 8'h00},
                           {2'h1, 1'h1, 1'h1, 8'h2A, 3'h1, 8'h71},
                           {2'h2, 1'h0, 1'h1, 8'h2B, 3'h2, 8'h9A},
                           {2'h3, 1'h1, 1'h0, 8'h4F, 3'h4, 8'hEC}};

  fhp_port i_dut (.*);
  fhp_host_mdl i_host (.mclk_i(mclk_i), .data_i(data_out_o), .chip_sel_n_o(chip_sel_n_i),
    .pick_o(register_pick_i), .strobe_a_o(strobe_a_i), .strobe_b_o(strobe_b_i),
    .data_o(data_in_i), .grant_n_o(dma_grant_n_i), .terminate_n_o(dma_terminate_n_i));

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // pulses sampled mid-cycle so they are settled
  always @(negedge mclk_i) begin
    cyc++;
    if (abort_o === 1'h1) n_abort++;
    if (ctl_wr_valid_o === 1'h1 && ctl_wr_ready_i) n_wr++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_byte
  task chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: bit %b want %b", $time, got, exp);
    end
  endtask : chk_bit
  task test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task go;
    @(negedge mclk_i) cmd_start_i = 1'h1;
    @(negedge mclk_i) cmd_start_i = 1'h0;
    repeat (3) @(negedge mclk_i);
  endtask : go
  task fin;
    @(negedge mclk_i) cmd_done_i = 1'h1;
    @(negedge mclk_i) cmd_done_i = 1'h0;
    repeat (2) @(negedge mclk_i);
  endtask : fin

  initial begin
    reset_i = 1'h1;
    repeat (6) @(negedge mclk_i);
    reset_i = 1'h0;
    repeat (6) @(negedge mclk_i);
    chk_bit(irq_n_o, 1'h1);
    chk_bit(dma_ask_n_o, 1'h1);
    chk_bit(data_oe_o, 1'h0);
    i_host.xfer(1'h0, 1'h1, fhp_pkg::REG_STATUS, 8'h00, rd);
    chk_byte(rd, fhp_pkg::STATUS_RESET);
    chk_bit(bit_rate_kbps_o == 10'(fhp_pkg::RATE_FM_SMALL), 1'h1);
    chk_bit(format_layout_o, 1'h0);
    foreach (rows[i]) begin
      {cmd_drive_i, cmd_head_i, cmd_inward_i, cmd_track_i, cmd_step_i, cmd_fault_clear_i,
       cmd_head_engage_i} = rows[i].stim;
      go();
      chk_byte({drive_pick_1_o, drive_pick_0_o, head_side_o, head_step_way_o,
        reduced_write_current_o, step_o, drive_fault_clear_o, head_engage_o}, rows[i].want);
      fin();
    end
    {cmd_step_i, cmd_fault_clear_i, cmd_head_engage_i} = 3'h0;
    cmd_setup2_i = 1'h1;
    cmd_lct_track_i = 8'h10;
    go();
    fin();
    cmd_setup2_i = 1'h0;
    for (int t = 15; t < 17; t++) begin
      cmd_track_i = t[7:0];
      go();
      chk_bit(reduced_write_current_o, t >= 16);
      fin();
    end
    i_host.xfer(1'h0, 1'h0, fhp_pkg::REG_DATA, 8'h5A, rd);
    chk_byte(ctl_wr_data_o, 8'h5A);
    i_host.xfer(1'h0, 1'h0, fhp_pkg::REG_STATUS, 8'h12, rd);
    chk_byte({n_abort[3:0], n_wr[3:0]}, 8'h01);
    i_host.xfer(1'h0, 1'h0, fhp_pkg::REG_STATUS, fhp_pkg::ABORT_CODE, rd);
    chk_byte({n_abort[3:0], n_wr[3:0]}, 8'h11);
    // fill until the buffer refuses, then drain it slowly through the host
    {cmd_rw_i, cmd_host_reads_i} = 2'h3;
    go();
    n = 0;
    repeat (20) begin
      @(negedge mclk_i);
      ctl_rd_valid_i = ctl_rd_ready_o;
      ctl_rd_data_i = 8'h30 + n[7:0];
      if (ctl_rd_ready_o) n++;
    end
    @(negedge mclk_i) ctl_rd_valid_i = 1'h0;
    chk_byte(n[7:0], fhp_pkg::FIFO_DEPTH[7:0]);
    for (int i = 0; i < 16; i++) begin
      i_host.xfer(1'h0, 1'h1, fhp_pkg::REG_STATUS, 8'h00, rd);
      chk_bit(rd[fhp_pkg::ST_TXR], 1'h1);
      chk_bit(rd[fhp_pkg::ST_DIR], 1'h1);
      chk_bit(rd[fhp_pkg::ST_PIO], 1'h1);
      i_host.xfer(1'h0, 1'h1, fhp_pkg::REG_DATA, 8'h00, rd);
      chk_byte(rd, 8'h30 + i[7:0]);
    end
    fin();
    {cmd_use_dma_i, cmd_rw_i, cmd_host_reads_i} = 3'h7;
    go();
    ctl_rd_data_i = 8'hC3;
    ctl_rd_valid_i = 1'h1;
    @(negedge mclk_i) ctl_rd_valid_i = 1'h0;
    n = 0;
    while (dma_ask_n_o !== 1'h0 && n < 50) begin
      @(negedge mclk_i);
      n++;
    end
    chk_bit(dma_ask_n_o, 1'h0);
    i_host.xfer(1'h1, 1'h1, fhp_pkg::REG_STATUS, 8'h00, rd);
    chk_byte(rd, 8'hC3);
    i_host.end_dma();
    repeat (4) @(negedge mclk_i);
    chk_bit(dma_ask_n_o, 1'h1);
    fin();
    {cmd_use_dma_i, cmd_rw_i, cmd_host_reads_i} = 3'h0;
    cmd_is_seek_i = 1'h1;
    cmd_drive_i = 2'h2;
    go();
    i_host.xfer(1'h0, 1'h1, fhp_pkg::REG_STATUS, 8'h00, rd);
    chk_byte({4'h0, rd[3:0]}, 8'h04);
    fin();
    cmd_is_seek_i = 1'h0;
    repeat (3) @(negedge mclk_i);
    chk_bit(irq_n_o, 1'h0);
    test_done();
  end
endmodule : fhp_port_tb
